/* rtl/kwi_pkg.sv */
// Package with register map, field positions and reset values.
package kwi_pkg;
    localparam int KWI_NUM_PINS = 8;
    localparam logic [3:0] KWI_OFS_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] KWI_OFS_PIN_ENABLE = 4'h4;
    localparam logic [3:0] KWI_OFS_EDGE_SELECT = 4'h8;
    localparam logic [3:0] KWI_OFS_WAKE_CONTROL = 4'hc;
    localparam int KWI_BIT_FLAG = 3;
    localparam int KWI_BIT_ACK = 2;
    localparam int KWI_BIT_IRQ_EN = 1;
    localparam int KWI_BIT_LEVEL_MODE = 0;
    localparam int KWI_BIT_STOP_LIGHT = 0;
    localparam int KWI_BIT_STOP_DEEP = 1;
    localparam logic [7:0] KWI_RST_PIN_ENABLE = 8'h00;
    localparam logic [7:0] KWI_RST_EDGE_SELECT = 8'h00;
    localparam logic KWI_RST_BIT = 1'b0;
    localparam logic [1:0] KWI_RESP_OKAY = 2'h0;
    localparam logic [1:0] KWI_RESP_SLVERR = 2'h2;
endpackage : kwi_pkg

/* rtl/kwi_keypad_wake_interrupt.sv */
// Keypad wake interrupt unit with an AXI4-Lite register slave.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module kwi_keypad_wake_interrupt
    import kwi_pkg::*;
#(
    parameter int NUM_PINS = KWI_NUM_PINS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [NUM_PINS-1:0] keypadInputPin,
    input wire logic [NUM_PINS-1:0] portPullEnable,
    output logic [NUM_PINS-1:0] pullUpEnable,
    output logic [NUM_PINS-1:0] pullDownEnable,
    output logic keypadIrq,
    output logic wakeRequest,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // Refuse a pin count that the eight-bit registers cannot serve.
    if (NUM_PINS < 1 || NUM_PINS > 8) begin : g_bad_pins
        $error("NUM_PINS must be 1 to 8");
    end

    logic [NUM_PINS-1:0] pinSync1_r;
    logic [NUM_PINS-1:0] pinSync2_r;
    logic [NUM_PINS-1:0] pinPrev_r;
    logic [NUM_PINS-1:0] pinDetectEnable_r;
    logic [NUM_PINS-1:0] pinPolaritySelect_r;
    logic keypadEventFlag_r;
    logic keypadIrqEnable_r;
    logic detectLevelMode_r;
    logic stopLight_r;
    logic stopDeep_r;
    logic armed_r;
    logic [NUM_PINS-1:0] asserted;
    logic [NUM_PINS-1:0] prevAsserted;
    logic [NUM_PINS-1:0] edgeHit;
    logic anyAsserted;
    logic detect;
    logic ackWrite;

    // Write channel holding registers; address and data may come in
    // either order and are joined before the write takes effect.
    logic awHeld_r;
    logic wHeld_r;
    logic [3:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    logic doWrite;

    // Pins come from outside, so two flops guard against metastability.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinSync1_r <= '0;
            pinSync2_r <= '0;
            pinPrev_r <= '0;
        end else begin
            pinSync1_r <= keypadInputPin;
            pinSync2_r <= pinSync1_r;
            pinPrev_r <= pinSync2_r;
        end
    end

    // Active level per pin follows its polarity bit; disabled pins are masked.
    always_comb begin
        asserted = (pinSync2_r ~^ pinPolaritySelect_r)
            & pinDetectEnable_r;
        prevAsserted = (pinPrev_r ~^ pinPolaritySelect_r)
            & pinDetectEnable_r;
        edgeHit = asserted & ~prevAsserted;
        anyAsserted = |asserted;
        detect = (armed_r && |edgeHit) || (detectLevelMode_r && anyAsserted);
    end

    // Arming: after an edge every enabled input must go idle first.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            armed_r <= KWI_RST_BIT;
        end else if (!anyAsserted) begin
            armed_r <= 1'b1;
        end else if (|edgeHit) begin
            armed_r <= 1'b0;
        end
    end

    assign doWrite = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign ackWrite = doWrite && awAddr_r == KWI_OFS_STATUS_CONTROL
        && wStrb_r[0] && wData_r[KWI_BIT_ACK];

    // Set wins over acknowledge; level mode refuses to clear while asserted.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            keypadEventFlag_r <= KWI_RST_BIT;
        end else if (detect) begin
            keypadEventFlag_r <= 1'b1;
        end else if (ackWrite && !(detectLevelMode_r && anyAsserted)) begin
            keypadEventFlag_r <= 1'b0;
        end
    end

    // Control registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            keypadIrqEnable_r <= KWI_RST_BIT;
            detectLevelMode_r <= KWI_RST_BIT;
            pinDetectEnable_r <= KWI_RST_PIN_ENABLE[NUM_PINS-1:0];
            pinPolaritySelect_r <= KWI_RST_EDGE_SELECT[NUM_PINS-1:0];
            stopLight_r <= KWI_RST_BIT;
            stopDeep_r <= KWI_RST_BIT;
        end else if (stopDeep_r && |(asserted)) begin
            // Leaving deep stop returns the control registers to their reset state; the event flag is kept.
            keypadIrqEnable_r <= KWI_RST_BIT;
            detectLevelMode_r <= KWI_RST_BIT;
            pinDetectEnable_r <= KWI_RST_PIN_ENABLE[NUM_PINS-1:0];
            pinPolaritySelect_r <= KWI_RST_EDGE_SELECT[NUM_PINS-1:0];
            stopLight_r <= KWI_RST_BIT;
            stopDeep_r <= KWI_RST_BIT;
        end else if (doWrite && wStrb_r[0]) begin
            case (awAddr_r)
                KWI_OFS_STATUS_CONTROL: begin
                    keypadIrqEnable_r <= wData_r[KWI_BIT_IRQ_EN];
                    detectLevelMode_r <= wData_r[KWI_BIT_LEVEL_MODE];
                end
                KWI_OFS_PIN_ENABLE: begin
                    pinDetectEnable_r <= wData_r[NUM_PINS-1:0];
                end
                KWI_OFS_EDGE_SELECT: begin
                    pinPolaritySelect_r <= wData_r[NUM_PINS-1:0];
                end
                KWI_OFS_WAKE_CONTROL: begin
                    stopLight_r <= wData_r[KWI_BIT_STOP_LIGHT];
                    stopDeep_r <= wData_r[KWI_BIT_STOP_DEEP];
                end
                default: begin
                end
            endcase
        end
    end

    // Request and pad controls. The request keeps working in wait and
    // debug modes since the block has no notion of them.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            keypadIrq <= 1'b0;
            wakeRequest <= 1'b0;
            pullUpEnable <= '0;
            pullDownEnable <= '0;
        end else begin
            keypadIrq <= keypadEventFlag_r && keypadIrqEnable_r;
            // Light stop with the interrupt enabled wakes on any enabled asserted input, edge or level.
            wakeRequest <= (stopLight_r && keypadIrqEnable_r && anyAsserted)
                || (keypadEventFlag_r && keypadIrqEnable_r);
            pullUpEnable <= portPullEnable & ~pinPolaritySelect_r;
            pullDownEnable <= portPullEnable & pinPolaritySelect_r;
        end
    end

    // Next values of the channel flags. The ready outputs are registered
    // from them, so each ready shows what the flags will hold after the
    // edge without any logic between a flop and the pin.
    logic awHeld_nxt;
    logic wHeld_nxt;
    logic bValid_nxt;
    logic rValid_nxt;

    always_comb begin
        awHeld_nxt = awHeld_r;
        wHeld_nxt = wHeld_r;
        bValid_nxt = s_axi_bvalid;
        rValid_nxt = s_axi_rvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_nxt = 1'b1;
        end
        if (doWrite) begin
            awHeld_nxt = 1'b0;
            wHeld_nxt = 1'b0;
            bValid_nxt = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            bValid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_nxt = 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            rValid_nxt = 1'b0;
        end
    end

    // AXI4-Lite write path.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 4'h0;
            wData_r <= 32'h0;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= KWI_RESP_OKAY;
        end else begin
            awHeld_r <= awHeld_nxt;
            wHeld_r <= wHeld_nxt;
            s_axi_bvalid <= bValid_nxt;
            s_axi_bresp <= KWI_RESP_OKAY;
            if (s_axi_awvalid && s_axi_awready) begin
                awAddr_r <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
        end
    end

    // Ready outputs; all three stand high out of reset.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_awready <= !awHeld_nxt && !bValid_nxt;
            s_axi_wready <= !wHeld_nxt && !bValid_nxt;
            s_axi_arready <= !rValid_nxt;
        end
    end

    // AXI4-Lite read path.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= KWI_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= KWI_RESP_OKAY;
            case ({s_axi_araddr[3:2], 2'b00})
                KWI_OFS_STATUS_CONTROL: begin
                    // Upper bits and the acknowledge bit read as zero.
                    s_axi_rdata <= {28'h0, keypadEventFlag_r, 1'b0,
                        keypadIrqEnable_r, detectLevelMode_r};
                end
                KWI_OFS_PIN_ENABLE: begin
                    s_axi_rdata <= 32'(pinDetectEnable_r);
                end
                KWI_OFS_EDGE_SELECT: begin
                    s_axi_rdata <= 32'(pinPolaritySelect_r);
                end
                KWI_OFS_WAKE_CONTROL: begin
                    s_axi_rdata <= {30'h0, stopDeep_r, stopLight_r};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : kwi_keypad_wake_interrupt

/* testbench/kwi_keypad_properties.sv */
// Port-level checker for the keypad wake interrupt unit.
`timescale 1ns/1ps
module kwi_keypad_properties
    import kwi_pkg::*;
#(
    parameter int NUM_PINS = KWI_NUM_PINS
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [NUM_PINS-1:0] pullUpEnable,
    input wire logic [NUM_PINS-1:0] pullDownEnable,
    input wire logic keypadIrq,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid
);
    logic [3:0] wAddr_r;
    logic [3:0] rAddr_r;
    logic maskWr_r;
    // Remember the last accepted addresses so answers can be judged.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wAddr_r <= 4'h0;
            rAddr_r <= 4'h0;
            maskWr_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) wAddr_r <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) rAddr_r <= s_axi_araddr;
            if (s_axi_wvalid && s_axi_wready)
                maskWr_r <= s_axi_wstrb[0] && !s_axi_wdata[KWI_BIT_IRQ_EN];
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read response late");
    a_bus_blocked: assert property ((s_axi_bvalid |-> !s_axi_awready &&
        !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready))
        else $error("request taken while answer pending");
    a_status_zeros: assert property (
        s_axi_rvalid && rAddr_r == KWI_OFS_STATUS_CONTROL
        |-> s_axi_rdata[7:4] == 4'h0 && !s_axi_rdata[KWI_BIT_ACK])
        else $error("status reads nonzero reserved or ack bits");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 0)
        else $error("read data upper bits set");
    a_pull_exclusive: assert property (
        (pullUpEnable & pullDownEnable) == '0)
        else $error("pull-up and pull-down both on");
    a_irq_masked: assert property (
        $rose(s_axi_bvalid) && wAddr_r == KWI_OFS_STATUS_CONTROL && maskWr_r
        |-> ##2 !keypadIrq) else $error("request not masked");
    a_reset_clear: assert property ($rose(rst_n) |->
        pullUpEnable == '0 && pullDownEnable == '0 && !keypadIrq)
        else $error("outputs not cleared by reset");
endmodule : kwi_keypad_properties

bind kwi_keypad_wake_interrupt kwi_keypad_properties #(.NUM_PINS(NUM_PINS))
    u_props (.mclk(mclk), .rst_n(rst_n), .pullUpEnable(pullUpEnable),
    .pullDownEnable(pullDownEnable), .keypadIrq(keypadIrq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid));

/* testbench/kwi_switch_model.sv */
// Keypad switch model that drives the unit's input pins.
`timescale 1ns/1ps
module kwi_switch_model (
    input wire logic [7:0] press,
    input wire logic [7:0] polarity,
    output logic [7:0] pins
);
    // A released key rests at the level its pull resistor gives.
    assign pins = ~(press ^ polarity);
endmodule : kwi_switch_model

/* testbench/keypad_wake_interrupt_test.sv */
// Self-checking bench for the keypad wake interrupt unit.
`timescale 1ns/1ps
module keypad_wake_interrupt_test;
    import kwi_pkg::*;
    localparam logic [3:0] SC = KWI_OFS_STATUS_CONTROL;
    logic mclk, rst_n, keypadIrq, awvalid, awready, wvalid, wready, bvalid;
    logic arvalid, arready, rvalid, ie;
    logic [7:0] pin, pullEn, press, pol, pu, pd;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, v, seed;
    int errors, checks_done;
    kwi_switch_model model (.press(press), .polarity(pol), .pins(pin));
    kwi_keypad_wake_interrupt dut (.mclk(mclk), .rst_n(rst_n),
        .keypadInputPin(pin), .portPullEnable(pullEn), .pullUpEnable(pu),
        .pullDownEnable(pd), .keypadIrq(keypadIrq), .wakeRequest(),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [31:0] stat(input logic f, e, lvl);
        return {28'h0, f, 1'b0, e, lvl};
    endfunction : stat
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask : wt
    // Each channel is released only at the edge that takes it.
    task automatic xfer(input logic wr, input logic [3:0] a,
                        input logic [7:0] d);
        awaddr <= a;
        araddr <= a;
        wdata <= {24'h0, d};
        awvalid <= wr;
        wvalid <= wr;
        arvalid <= !wr;
        do begin
            @(posedge mclk);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
            if (arready && arvalid) arvalid <= 1'b0;
            if (rvalid) rd = rdata;
        end while (!(bvalid || rvalid));
    endtask : xfer
    task automatic rs(input logic [31:0] exp);
        xfer(1'b0, SC, 8'h00);
        chk(rd, exp);
    endtask : rs
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // The whole sequence needs well under 2000 cycles; allow far more.
    initial begin
        #2000000;
        errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        {rst_n, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
        {press, pol, pullEn} = '0;
        seed = 32'h55;
        wt(5);
        rst_n <= 1'b1;
        wt(1);
        for (int a = 0; a < 12; a += 4) begin
            xfer(1'b0, a[3:0], 8'h00);
            chk(rd, 32'h0);
        end
        xfer(1'b1, SC, 8'hfc);
        rs(stat(0, 0, 0));
        xfer(1'b1, SC, 8'h03);
        rs(stat(0, 1, 1));
        repeat (4) begin
            v = rnd();
            pullEn <= v[23:16];
            pol <= v[15:8];
            xfer(1'b1, KWI_OFS_PIN_ENABLE, v[7:0]);
            xfer(1'b1, KWI_OFS_EDGE_SELECT, v[15:8]);
            xfer(1'b0, KWI_OFS_PIN_ENABLE, 8'h00);
            chk(rd, {24'h0, v[7:0]});
            xfer(1'b0, KWI_OFS_EDGE_SELECT, 8'h00);
            chk(rd, {24'h0, v[15:8]});
            chk({16'h0, pd, pu},
                {16'h0, v[23:16] & v[15:8], v[23:16] & ~v[15:8]});
        end
        $display("register access tested");
        xfer(1'b1, SC, 8'h00);
        xfer(1'b1, KWI_OFS_PIN_ENABLE, 8'hff);
        for (int i = 0; i < 8; i++) begin
            ie = i[0];
            xfer(1'b1, SC, {6'h01, ie, 1'b0});
            press <= 8'(8'h01 << i);
            wt(6);
            chk({31'h0, keypadIrq}, {31'h0, ie});
            rs(stat(1, ie, 0));
            press <= 8'h00;
            wt(4);
            xfer(1'b1, SC, {6'h01, ie, 1'b0});
            rs(stat(0, ie, 0));
        end
        $display("edge detection tested");
        press <= 8'h01;
        wt(6);
        xfer(1'b1, SC, 8'h04);
        press <= 8'h03;
        wt(6);
        rs(stat(0, 0, 0));
        press <= 8'h00;
        wt(6);
        press <= 8'h02;
        wt(6);
        rs(stat(1, 0, 0));
        xfer(1'b1, KWI_OFS_PIN_ENABLE, 8'hfe);
        press <= 8'h00;
        wt(6);
        xfer(1'b1, SC, 8'h04);
        press <= 8'h01;
        wt(6);
        rs(stat(0, 0, 0));
        $display("rearm and pin enable tested");
        xfer(1'b1, KWI_OFS_PIN_ENABLE, 8'h00);
        press <= 8'hff;
        wt(6);
        xfer(1'b1, KWI_OFS_PIN_ENABLE, 8'hff);
        xfer(1'b1, SC, 8'h04);
        wt(6);
        rs(stat(0, 0, 0));
        xfer(1'b1, SC, 8'h07);
        wt(6);
        rs(stat(1, 1, 1));
        chk({31'h0, keypadIrq}, 32'h1);
        xfer(1'b1, SC, 8'h07);
        rs(stat(1, 1, 1));
        press <= 8'h00;
        wt(6);
        xfer(1'b1, SC, 8'h07);
        rs(stat(0, 1, 1));
        chk({31'h0, keypadIrq}, 32'h0);
        $display("level mode tested");
        end_of_test();
    end
endmodule : keypad_wake_interrupt_test
